// ---- rtl/timer3_map.vh ----
// Register layout and field positions of the timer control block
`ifndef TIMER3_MAP_VH
`define TIMER3_MAP_VH
`define CTRL_ADDR       8'h91
`define RLL_ADDR        8'h92
`define RLH_ADDR        8'h93
`define CNTL_ADDR       8'h94
`define CNTH_ADDR       8'h95
`define CTRL_RESET      8'h00
`define BIT_HFLAG       7
`define BIT_LFLAG       6
`define BIT_LIRQEN      5
`define BIT_CAPEN       4
`define BIT_SPLIT       3
`define BIT_RUN         2
`endif

// ---- rtl/timer3_control.v ----
// Third timer: control register, overflow flags, capture and split counting
`timescale 1ns/1ps
`default_nettype none
`include "timer3_map.vh"

//
// Contract
// RULE1 - Low overflow with enables raises interrupt
// RULE2 - Capture mode follows capture enable bit
// RULE3 - Capture event requests interrupt when enabled
// RULE4 - Capture copies full count into reloads
// RULE5 - Split bit selects two 8-bit counters
// RULE6 - Run gates high byte only in split
// RULE7 - Overflow reloads low byte from reload
// RULE8 - High flag sticky until software clears
module timer3_control (
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Register port
	input  wire [7:0] regAddr,
	input  wire       regWr,
	input  wire [7:0] regWdata,
	output reg  [7:0] regRdata,
	// Timer events
	input  wire       countTick,
	input  wire       captureEvent,
	input  wire       timerIrqEnable,
	// Interrupt request
	output wire       irqRequest
);

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	reg rstMeta_reg;
	reg rstSync_reg;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [7:0] ctrl_reg;
	reg  [7:0] rll_reg;
	reg  [7:0] rlh_reg;
	reg  [7:0] cntL_reg;
	reg  [7:0] cntH_reg;
	reg        capPend_reg;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Write strobe aimed at one register address
	function writeHit;
		input       wrStrobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			writeHit = wrStrobe & (addr == target);
		end
	endfunction

	// Counter byte at its last value before wrapping
	function atTop;
		input [7:0] value;
		begin
			atTop = (value == 8'hff);
		end
	endfunction

	wire ctrlWr   = writeHit(regWr, regAddr, `CTRL_ADDR);
	wire rllWr    = writeHit(regWr, regAddr, `RLL_ADDR);
	wire rlhWr    = writeHit(regWr, regAddr, `RLH_ADDR);
	wire cntLWr   = writeHit(regWr, regAddr, `CNTL_ADDR);
	wire cntHWr   = writeHit(regWr, regAddr, `CNTH_ADDR);

	// ----------------------------------------
	// Mode and count enables
	// ----------------------------------------
	// RULE2 capture mode bit
	wire capMode  = ctrl_reg[`BIT_CAPEN];
	// RULE5 split mode bit
	wire split    = ctrl_reg[`BIT_SPLIT];
	wire run      = ctrl_reg[`BIT_RUN];
	// RULE6 run gates high only in split, both bytes otherwise
	wire lowRun   = countTick & (split | run);
	wire highRun  = countTick & run;
	wire lowOvf   = lowRun & atTop(cntL_reg);
	wire highOvf  = split ? (highRun & atTop(cntH_reg)) : (lowOvf & atTop(cntH_reg));
	wire capEvt   = capMode & captureEvent;

	// ----------------------------------------
	// Control and flags
	// ----------------------------------------
	reg  [7:0] ctrl_next;
	reg        capPend_next;

	// Hardware flag set wins over a same-cycle clear
	always @* begin
		ctrl_next    = ctrl_reg;
		capPend_next = capPend_reg;
		if (ctrlWr)
			ctrl_next = regWdata;
		// RULE8 sticky high flag
		if (highOvf)
			ctrl_next[`BIT_HFLAG] = 1'b1;
		// Low flag on every low overflow
		if (lowOvf)
			ctrl_next[`BIT_LFLAG] = 1'b1;
		// RULE3 capture request
		if (capEvt)
			capPend_next = 1'b1;
		else if (ctrlWr && !regWdata[`BIT_HFLAG])
			capPend_next = 1'b0;
	end

	always @(posedge clk or negedge rstSync_reg) begin
		if (!rstSync_reg) begin
			ctrl_reg    <= `CTRL_RESET;
			capPend_reg <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			capPend_reg <= capPend_next;
		end
	end

	// RULE1 low byte interrupt
	assign irqRequest = timerIrqEnable & (ctrl_reg[`BIT_HFLAG] | capPend_reg
		| (ctrl_reg[`BIT_LFLAG] & ctrl_reg[`BIT_LIRQEN]));

	// ----------------------------------------
	// Counters and reload registers
	// ----------------------------------------
	reg  [7:0] rll_next;
	reg  [7:0] rlh_next;
	reg  [7:0] cntL_next;
	reg  [7:0] cntH_next;

	// Counting and capture win over a same-cycle software write
	always @* begin
		rll_next  = rll_reg;
		rlh_next  = rlh_reg;
		cntL_next = cntL_reg;
		cntH_next = cntH_reg;
		// RULE4 capture copies count
		if (capEvt) begin
			rll_next = cntL_reg;
			rlh_next = cntH_reg;
		end else begin
			if (rllWr)
				rll_next = regWdata;
			if (rlhWr)
				rlh_next = regWdata;
		end
		// RULE7 low reload on overflow
		if (lowOvf && (split || highOvf))
			cntL_next = rll_reg;
		else if (lowRun)
			cntL_next = cntL_reg + 8'h01;
		else if (cntLWr)
			cntL_next = regWdata;
		// RULE5 split or cascaded high byte
		if (highOvf)
			cntH_next = rlh_reg;
		else if (split ? highRun : lowOvf)
			cntH_next = cntH_reg + 8'h01;
		else if (cntHWr)
			cntH_next = regWdata;
	end

	always @(posedge clk or negedge rstSync_reg) begin
		if (!rstSync_reg) begin
			rll_reg  <= 8'h00;
			rlh_reg  <= 8'h00;
			cntL_reg <= 8'h00;
			cntH_reg <= 8'h00;
		end else begin
			rll_reg  <= rll_next;
			rlh_reg  <= rlh_next;
			cntL_reg <= cntL_next;
			cntH_reg <= cntH_next;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	reg  [7:0] rdata_next;

	// Unmapped addresses read as zero
	always @* begin
		if (regAddr == `CTRL_ADDR)
			rdata_next = ctrl_reg;
		else if (regAddr == `RLL_ADDR)
			rdata_next = rll_reg;
		else if (regAddr == `RLH_ADDR)
			rdata_next = rlh_reg;
		else if (regAddr == `CNTL_ADDR)
			rdata_next = cntL_reg;
		else if (regAddr == `CNTH_ADDR)
			rdata_next = cntH_reg;
		else
			rdata_next = 8'h00;
	end

	// Read data registered one cycle after the address
	always @(posedge clk or negedge rstSync_reg) begin
		if (!rstSync_reg)
			regRdata <= 8'h00;
		else
			regRdata <= rdata_next;
	end

endmodule
`default_nettype wire

// ---- bench/timer3_control_assertions.sv ----
// Port checks of the timer block
`timescale 1ns/1ps
`default_nettype none
module timer3_control_assertions (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [7:0] regAddr,
	input wire logic       regWr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic       countTick,
	input wire logic       captureEvent,
	input wire logic       timerIrqEnable,
	input wire logic       irqRequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	irq_gate_a: assert property (!timerIrqEnable |-> !irqRequest) else $error("irq");
	ctrl_keep_a: assert property (regWr && regAddr == 8'h91 ##1 !regWr && regAddr == 8'h91
		|=> regRdata[5:2] == $past(regWdata[5:2], 2)) else $error("ctrl");
	flag_sticky_a: assert property ((regAddr == 8'h91 && !regWr) ##1
		(regAddr == 8'h91 && !regWr && regRdata[7]) |=> regRdata[7])
		else $error("high flag lost");
	irq_flag_a: assert property ((regAddr == 8'h91 && !regWr) ##1
		(regRdata[7] && timerIrqEnable) |-> irqRequest)
		else $error("high flag irq missing");
	reload_keep_a: assert property ((regWr && regAddr == 8'h92 && !captureEvent) ##1
		(!regWr && regAddr == 8'h92 && !captureEvent) |=> regRdata == $past(regWdata, 2))
		else $error("reload low lost");
	capture_irq_a: assert property ((regAddr == 8'h91 && !regWr) ##1
		(regRdata[4] && captureEvent) |=> (!timerIrqEnable || irqRequest))
		else $error("capture irq missing");
endmodule
bind timer3_control timer3_control_assertions chk (.clk(clk), .nrst(nrst),
	.regAddr(regAddr), .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
	.countTick(countTick), .captureEvent(captureEvent),
	.timerIrqEnable(timerIrqEnable), .irqRequest(irqRequest));
`default_nettype wire

// ---- bench/test_timer3_control.sv ----
// Directed test of the timer block
`timescale 1ns/1ps
`default_nettype none
module test_timer3_control;
	logic       clk = 0, nrst = 0, wr = 0, ie = 1;
	logic [7:0] ad = 8'h90, wd = 0;
	logic [1:0] ev = 0;
	wire  [7:0] rdat;
	wire        irq;
	int         mismatches = 0, checks = 0;
	timer3_control dut (.clk(clk), .nrst(nrst), .regAddr(ad), .regWr(wr), .regWdata(wd),
		.regRdata(rdat), .countTick(ev[0]), .captureEvent(ev[1]),
		.timerIrqEnable(ie), .irqRequest(irq));
	initial forever #2 clk = ~clk;
	task c(input logic [7:0] g, e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask
	task w(input logic [7:0] a, d);
		@(negedge clk) {ad, wd, wr} = {a, d, 1'b1};
		@(negedge clk) wr = 0;
	endtask
	task r(input logic [7:0] a, e);
		@(negedge clk) ad = a;
		@(negedge clk) c(rdat, e);
	endtask
	task p(input logic [1:0] e);
		@(negedge clk) ev = e;
		@(negedge clk) ev = 0;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#2000;
		mismatches++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1;
		repeat (3) @(negedge clk);
		r(8'h91, 8'h00);
		w(8'h92, 8'h12);
		w(8'h93, 8'h34);
		w(8'h94, 8'hff);
		w(8'h95, 8'hff);
		w(8'h91, 8'h04);
		p(2'b01);
		r(8'h91, 8'hc4);
		r(8'h94, 8'h12);
		r(8'h95, 8'h34);
		c(irq, 8'h01);
		w(8'h91, 8'h10);
		w(8'h94, 8'h56);
		r(8'h91, 8'h10);
		p(2'b10);
		c(irq, 8'h01);
		r(8'h92, 8'h56);
		r(8'h93, 8'h34);
		ie = 0;
		#1 c(irq, 8'h00);
		w(8'h91, 8'h08);
		w(8'h94, 8'hff);
		p(2'b01);
		r(8'h94, 8'h56);
		r(8'h95, 8'h34);
		r(8'h91, 8'h48);
		ie = 1;
		w(8'h91, 8'h28);
		w(8'h94, 8'hff);
		c(irq, 8'h00);
		p(2'b01);
		c(irq, 8'h01);
		report_and_stop;
	end
endmodule
`default_nettype wire
